// [rpc_pkg.sv]
// Package of constants, types and helpers for the read prefetch control block.
package rpc_pkg;
  localparam logic [11:0] RPC_ADDR_CTRL   = 12'h040;
  localparam logic [11:0] RPC_ADDR_AUX    = 12'h044;
  localparam logic [15:0] RPC_CTRL_RST    = 16'h0020;
  localparam int          RPC_B_PARK      = 0;
  localparam int          RPC_B_DYN_DIS   = 1;
  localparam int          RPC_B_PRED_DIS  = 2;
  localparam int          RPC_B_CFG_CONV  = 3;
  localparam int          RPC_F_RMULT     = 4;
  localparam int          RPC_F_RLINE     = 6;
  localparam int          RPC_F_RMEM      = 8;
  localparam int          RPC_B_SPECIAL   = 10;
  localparam int          RPC_B_MALF      = 11;
  localparam int          RPC_F_MAXBC     = 12;
  localparam int          RPC_B_SEC_TO    = 0;
  localparam int          RPC_DISCARD_LONG  = 32768;
  localparam int          RPC_DISCARD_SHORT = 1024;
  localparam logic [12:0] RPC_LINE_BYTES  = 13'h0020;
  localparam logic [12:0] RPC_DWORD_BYTES = 13'h0004;
  localparam logic [3:0]  RPC_CMD_MR      = 4'h6;
  localparam logic [3:0]  RPC_CMD_MRL     = 4'hE;
  localparam logic [3:0]  RPC_CMD_MRM     = 4'hC;

  typedef enum logic [1:0] {
    RPC_PF_LINE = 2'b00,
    RPC_PF_KEEP = 2'b01,
    RPC_PF_FULL = 2'b10,
    RPC_PF_BOTH = 2'b11
  } rpc_pf_e;

  typedef enum logic [1:0] {
    RPC_ST_IDLE    = 2'b00,
    RPC_ST_FETCH   = 2'b01,
    RPC_ST_DELIVER = 2'b10,
    RPC_ST_RETAIN  = 2'b11
  } rpc_state_e;

  typedef struct packed {
    logic        valid;
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic [3:0]  be;
    logic        pref;
  } rpc_rd_req_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [12:0] len;
  } rpc_pcie_req_s;

  typedef struct packed {
    logic        valid;
    logic        type1;
    logic [31:0] addr;
  } rpc_cfg_s;

  function automatic logic [12:0] rpc_max_bytes(input logic [2:0] code);
    case (code)
      3'b001:  rpc_max_bytes = 13'h0080;
      3'b010:  rpc_max_bytes = 13'h0100;
      3'b100:  rpc_max_bytes = 13'h0400;
      3'b101:  rpc_max_bytes = 13'h0800;
      3'b110:  rpc_max_bytes = 13'h1000;
      default: rpc_max_bytes = 13'h0200;
    endcase
  endfunction

  function automatic logic rpc_is_mem_read(input logic [3:0] cmd);
    rpc_is_mem_read = (cmd == RPC_CMD_MR) || (cmd == RPC_CMD_MRL) || (cmd == RPC_CMD_MRM);
  endfunction
endpackage

// [rpc_apb_regs.sv]
// APB slave holding the prefetch control register and the auxiliary register.
`timescale 1ns/100ps
module rpc_apb_regs
  import rpc_pkg::*;
(
  input  wire logic        pclk,     // Bus clock.
  input  wire logic        presetn,  // Asynchronous reset, active low.
  input  wire logic [11:0] paddr,    // Byte address.
  input  wire logic        psel,     // Slave select.
  input  wire logic        penable,  // Access phase.
  input  wire logic        pwrite,   // Write strobe.
  input  wire logic [31:0] pwdata,   // Write data.
  input  wire logic [7:0]  status,   // Live block state for readback.
  output logic      [31:0] prdata,   // Read data.
  output logic             pready,   // Always ready.
  output logic             pslverr,  // Unmapped address.
  output logic      [15:0] ctrl,     // Control register contents.
  output logic             sec_to    // Short discard timeout select.
);
  logic [15:0] ctrl_r, ctrl_nxt;
  logic        sec_to_r, sec_to_nxt;
  logic        hit_ctrl, hit_aux, wr;

  always_comb begin
    hit_ctrl   = (paddr == RPC_ADDR_CTRL);
    hit_aux    = (paddr == RPC_ADDR_AUX);
    wr         = psel && penable && pwrite;
    ctrl_nxt   = ctrl_r;
    sec_to_nxt = sec_to_r;
    if (wr && hit_ctrl) begin
      ctrl_nxt = pwdata[15:0];
    end
    if (wr && hit_aux) begin
      sec_to_nxt = pwdata[RPC_B_SEC_TO];
    end
    prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      prdata = {16'h0000, ctrl_r};
    end else if (hit_aux) begin
      prdata = {16'h0000, status, 7'h00, sec_to_r};
    end
    pready  = 1'b1;
    pslverr = psel && penable && !(hit_ctrl || hit_aux);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= RPC_CTRL_RST;
      sec_to_r <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      sec_to_r <= sec_to_nxt;
    end
  end

  assign ctrl   = ctrl_r;
  assign sec_to = sec_to_r;
endmodule

// [rpc_discard_timer.sv]
// Discard timer that bounds how long retained prefetch data is held.
`timescale 1ns/100ps
module rpc_discard_timer #(
  parameter int LONG_CLKS  = 32768,
  parameter int SHORT_CLKS = 1024
) (
  input  wire logic clk,        // Clock.
  input  wire logic rst_n,      // Asynchronous reset, active low.
  input  wire logic start,      // Load and run.
  input  wire logic stop,       // Halt without expiry.
  input  wire logic short_sel,  // Select the short count.
  output logic      expired     // One-cycle pulse at expiry.
);
  logic [16:0] cnt_r, cnt_nxt;
  logic        run_r, run_nxt;
  logic        exp_r, exp_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    exp_nxt = 1'b0;
    if (start) begin
      cnt_nxt = short_sel ? 17'(SHORT_CLKS - 1) : 17'(LONG_CLKS - 1);
      run_nxt = 1'b1;
    end else if (stop) begin
      run_nxt = 1'b0;
    end else if (run_r) begin
      if (cnt_r == 17'h00000) begin
        run_nxt = 1'b0;
        exp_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 17'h00001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 17'h00000;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign expired = exp_r;
endmodule

// [rpc_top.sv]
// Read path control of the bridge: arbiter parking, prefetch sizing and retention.
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module rpc_top
  import rpc_pkg::*;
#(
  parameter int NM           = 4,
  parameter int IW           = 2,
  parameter int DISCARD_LONG = RPC_DISCARD_LONG
) (
  input  wire logic          pclk,         // Secondary PCI clock.
  input  wire logic          presetn,      // Asynchronous reset, active low.
  input  wire logic [11:0]   paddr,        // APB address.
  input  wire logic          psel,         // APB select.
  input  wire logic          penable,      // APB enable.
  input  wire logic          pwrite,       // APB write.
  input  wire logic [31:0]   pwdata,       // APB write data.
  output logic      [31:0]   prdata,       // APB read data.
  output logic               pready,       // APB ready.
  output logic               pslverr,      // APB error.
  input  wire logic [NM-1:0] arb_req,      // Master bus requests.
  input  wire logic [IW-1:0] arb_last,     // Last granted master.
  output logic               park_own,     // Park on own port.
  output logic      [IW-1:0] park_idx,     // Master parked on.
  input  rpc_rd_req_s        rd_req,       // Read request from PCI target logic.
  output logic               rd_retry,     // Answer retry.
  output logic               rd_go,        // Answer with data.
  input  wire logic          xfer_end,     // Data phase of read ended.
  input  wire logic          term_master,  // Ended by the external master.
  input  wire logic          term_bridge,  // Ended by bridge disconnect.
  input  wire logic          data_left,    // Prefetched data unconsumed.
  output rpc_pcie_req_s      pcie_req,     // Memory read request to PCIe.
  input  wire logic          cpl_done,     // Completion data arrived.
  input  rpc_cfg_s           cfg_in,       // Config cycle from PCI.
  output rpc_cfg_s           cfg_out,      // Converted config cycle.
  output logic               dyn_pf_en,    // Dynamic prefetch control on.
  output logic               pred_en,      // Completion prediction on.
  output logic               malf_chk_en,  // Malformed packet checks on.
  output logic               discard_exp   // Retained data discarded.
);
  logic [15:0]   ctrl;
  logic          sec_to;
  logic          tmr_start, tmr_stop, tmr_exp;
  rpc_state_e    st_r, st_nxt;
  rpc_rd_req_s   held_r, held_nxt;
  rpc_pf_e       mode_r, mode_nxt;
  rpc_pcie_req_s preq_r, preq_nxt;
  rpc_cfg_s      cfg_r, cfg_nxt;
  logic          own_r, own_nxt;
  logic [IW-1:0] idx_r, idx_nxt;
  logic          flags_r [3];
  logic          flags_nxt [3];
  logic          same_ab, same_cmd, hit, keep;
  rpc_pf_e       sel_mode;
  logic [12:0]   sel_len;

  rpc_apb_regs u_regs (
    .pclk    (pclk),
    .presetn (presetn),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .status  ({6'h00, st_r}),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .ctrl    (ctrl),
    .sec_to  (sec_to)
  );

  rpc_discard_timer #(
    .LONG_CLKS  (DISCARD_LONG),
    .SHORT_CLKS (RPC_DISCARD_SHORT)
  ) u_tmr (
    .clk       (pclk),
    .rst_n     (presetn),
    .start     (tmr_start),
    .stop      (tmr_stop),
    .short_sel (sec_to),
    .expired   (tmr_exp)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Arbiter parking, configuration conversion and enable flags.

  always_comb begin
    own_nxt = own_r;
    idx_nxt = idx_r;
    if (arb_req == '0) begin
      own_nxt = ctrl[RPC_B_PARK];
      idx_nxt = arb_last;
    end
    cfg_nxt = cfg_in;
    if (cfg_in.valid && ctrl[RPC_B_CFG_CONV] && (cfg_in.addr[31:28] == 4'hF)) begin
      cfg_nxt.type1      = 1'b1;
      cfg_nxt.addr[1:0]  = 2'b01;
    end
    flags_nxt[0] = !ctrl[RPC_B_DYN_DIS];
    flags_nxt[1] = !ctrl[RPC_B_PRED_DIS];
    flags_nxt[2] = ctrl[RPC_B_MALF];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_r <= 1'b0;
      idx_r <= '0;
      cfg_r <= '0;
      for (int i = 0; i < 3; i++) begin
        flags_r[i] <= 1'b0;
      end
    end else begin
      own_r <= own_nxt;
      idx_r <= idx_nxt;
      cfg_r <= cfg_nxt;
      for (int i = 0; i < 3; i++) begin
        flags_r[i] <= flags_nxt[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Prefetch mode selection and request sizing.

  always_comb begin
    case (rd_req.cmd)
      RPC_CMD_MRM: sel_mode = rpc_pf_e'(ctrl[RPC_F_RMULT +: 2]);
      RPC_CMD_MRL: sel_mode = rpc_pf_e'(ctrl[RPC_F_RLINE +: 2]);
      default:     sel_mode = rpc_pf_e'(ctrl[RPC_F_RMEM +: 2]);
    endcase
    sel_len = RPC_LINE_BYTES;
    if (!rd_req.pref) begin
      sel_len = RPC_DWORD_BYTES;
    end else if (rd_req.cmd == RPC_CMD_MR) begin
      // The plain read field has no retention; 01 is treated as one line.
      case (sel_mode)
        RPC_PF_FULL: sel_len = rpc_max_bytes(ctrl[RPC_F_MAXBC +: 3]);
        RPC_PF_BOTH: sel_len = RPC_DWORD_BYTES;
        default:     sel_len = RPC_LINE_BYTES;
      endcase
    end else if (sel_mode != RPC_PF_LINE) begin
      sel_len = rpc_max_bytes(ctrl[RPC_F_MAXBC +: 3]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Delayed read tracking, retention and discard.

  always_comb begin
    same_ab  = (rd_req.addr == held_r.addr) && (rd_req.be == held_r.be);
    same_cmd = (rd_req.cmd == held_r.cmd);
    hit      = rd_req.valid && same_ab && (same_cmd ||
               (ctrl[RPC_B_SPECIAL] && rpc_is_mem_read(rd_req.cmd) &&
                rpc_is_mem_read(held_r.cmd)));
    keep     = data_left && (
               ((held_r.cmd == RPC_CMD_MRM) && (mode_r == RPC_PF_KEEP) && term_bridge) ||
               ((held_r.cmd == RPC_CMD_MRL) && (mode_r == RPC_PF_KEEP) && term_master) ||
               ((held_r.cmd != RPC_CMD_MR) && (mode_r == RPC_PF_BOTH)));
    st_nxt    = st_r;
    held_nxt  = held_r;
    mode_nxt  = mode_r;
    preq_nxt  = preq_r;
    preq_nxt.valid = 1'b0;
    rd_retry  = 1'b0;
    rd_go     = 1'b0;
    tmr_start = 1'b0;
    tmr_stop  = 1'b0;
    case (st_r)
      RPC_ST_IDLE: begin
        if (rd_req.valid && rpc_is_mem_read(rd_req.cmd)) begin
          rd_retry   = 1'b1;
          held_nxt   = rd_req;
          mode_nxt   = sel_mode;
          preq_nxt   = '{valid: 1'b1, addr: rd_req.addr, len: sel_len};
          st_nxt     = RPC_ST_FETCH;
        end
      end
      RPC_ST_FETCH: begin
        rd_retry = rd_req.valid;
        if (cpl_done) begin
          st_nxt = RPC_ST_DELIVER;
        end
      end
      RPC_ST_DELIVER: begin
        rd_go    = hit;
        rd_retry = rd_req.valid && !hit;
        if (xfer_end) begin
          if (keep) begin
            tmr_start = 1'b1;
            st_nxt    = RPC_ST_RETAIN;
          end else begin
            st_nxt = RPC_ST_IDLE;
          end
        end
      end
      RPC_ST_RETAIN: begin
        rd_go    = hit;
        rd_retry = rd_req.valid && !hit;
        if (hit) begin
          tmr_stop = 1'b1;
          st_nxt   = RPC_ST_DELIVER;
        end else if (tmr_exp) begin
          st_nxt = RPC_ST_IDLE;
        end
      end
      default: begin
        st_nxt = RPC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= RPC_ST_IDLE;
      held_r <= '0;
      mode_r <= RPC_PF_LINE;
      preq_r <= '0;
    end else begin
      st_r   <= st_nxt;
      held_r <= held_nxt;
      mode_r <= mode_nxt;
      preq_r <= preq_nxt;
    end
  end

  assign park_own    = own_r;
  assign park_idx    = idx_r;
  assign cfg_out     = cfg_r;
  assign pcie_req    = preq_r;
  assign dyn_pf_en   = flags_r[0];
  assign pred_en     = flags_r[1];
  assign malf_chk_en = flags_r[2];
  assign discard_exp = tmr_exp && (st_r == RPC_ST_RETAIN) && !hit;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_issue_full;
    (st_r == RPC_ST_IDLE) && rd_req.valid && rd_req.pref &&
    (rd_req.cmd == RPC_CMD_MRM) && (ctrl[5:4] != 2'b00);
  endsequence

  sequence s_issue_line;
    (st_r == RPC_ST_IDLE) && rd_req.valid && rd_req.pref &&
    (rd_req.cmd == RPC_CMD_MRL) && (ctrl[7:6] == 2'b00);
  endsequence

  property p_park;
    (arb_req == '0) && ctrl[0] |=> park_own;
  endproperty
  a_park: assert property (p_park) else $error("idle bus not parked on own port");

  // The flags leave reset at 0 and follow the control bits one edge later, dyn_pf_en and pred_en inverted.
  property p_flags;
    $past(presetn) |=> (dyn_pf_en == !$past(ctrl[1])) && (pred_en == !$past(ctrl[2])) &&
        (malf_chk_en == $past(ctrl[11]));
  endproperty
  a_flags: assert property (p_flags) else $error("enable flags disagree with control");

  property p_cfg;
    cfg_in.valid && ctrl[3] && (cfg_in.addr[31:28] == 4'hF)
      |=> cfg_out.type1 && (cfg_out.addr[1:0] == 2'b01);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config cycle not converted");

  property p_full_len;
    s_issue_full |=> pcie_req.valid && (pcie_req.len == rpc_max_bytes($past(ctrl[14:12])));
  endproperty
  a_full_len: assert property (p_full_len) else $error("full prefetch length wrong");

  property p_line_len;
    s_issue_line |=> pcie_req.valid && (pcie_req.len == 13'h0020);
  endproperty
  a_line_len: assert property (p_line_len) else $error("one line fetch length wrong");

  property p_retry_cmd;
    (st_r == RPC_ST_DELIVER) && rd_req.valid && !ctrl[10] && (rd_req.cmd != held_r.cmd)
      |-> rd_retry && !rd_go;
  endproperty
  a_retry_cmd: assert property (p_retry_cmd) else $error("changed command not retried");

  property p_special;
    (st_r == RPC_ST_DELIVER) && rd_req.valid && ctrl[10] && same_ab &&
    rpc_is_mem_read(rd_req.cmd) && rpc_is_mem_read(held_r.cmd) |-> rd_go;
  endproperty
  a_special: assert property (p_special) else $error("special delayed read not completed");

  property p_drop;
    (st_r == RPC_ST_DELIVER) && xfer_end && !keep |=> (st_r == RPC_ST_IDLE);
  endproperty
  a_drop: assert property (p_drop) else $error("data not dropped at read end");

  property p_keep_mult;
    (st_r == RPC_ST_DELIVER) && xfer_end && data_left && term_bridge &&
    (held_r.cmd == RPC_CMD_MRM) && (mode_r == RPC_PF_KEEP) |=> (st_r == RPC_ST_RETAIN);
  endproperty
  a_keep_mult: assert property (p_keep_mult) else $error("leftover data not retained");

  sequence s_read_end;
    (st_r == RPC_ST_DELIVER) && xfer_end;
  endsequence

  property p_mult_line;
    (st_r == RPC_ST_IDLE) && rd_req.valid && rd_req.pref && (rd_req.cmd == RPC_CMD_MRM) &&
    (ctrl[5:4] == 2'b00) |=> pcie_req.valid && (pcie_req.len == 13'h0020);
  endproperty
  a_mult_line: assert property (p_mult_line) else $error("one line multiple fetch wrong");

  property p_first_dword;
    (st_r == RPC_ST_IDLE) && rd_req.valid && rd_req.pref && (rd_req.cmd == RPC_CMD_MR) &&
    (ctrl[9:8] == 2'b11) |=> pcie_req.valid && (pcie_req.len == 13'h0004);
  endproperty
  a_first_dword: assert property (p_first_dword) else $error("first dword fetch wrong");

  property p_keep_both;
    s_read_end ##0 (data_left && (held_r.cmd != RPC_CMD_MR) && (mode_r == RPC_PF_BOTH))
      |=> (st_r == RPC_ST_RETAIN);
  endproperty
  a_keep_both: assert property (p_keep_both) else $error("leftover data not kept");

  property p_keep_line;
    s_read_end ##0 (data_left && term_master && (held_r.cmd == RPC_CMD_MRL) &&
    (mode_r == RPC_PF_KEEP)) |=> (st_r == RPC_ST_RETAIN);
  endproperty
  a_keep_line: assert property (p_keep_line) else $error("read line data not kept");

  property p_mr_drop;
    s_read_end ##0 (held_r.cmd == RPC_CMD_MR) |=> (st_r == RPC_ST_IDLE);
  endproperty
  a_mr_drop: assert property (p_mr_drop) else $error("plain read data kept");

  property p_discard;
    (st_r == RPC_ST_RETAIN) && tmr_exp && !hit |-> discard_exp ##1 (st_r == RPC_ST_IDLE);
  endproperty
  a_discard: assert property (p_discard) else $error("expired data not discarded");

  property p_park_last;
    $past(presetn) && (arb_req == '0) && !ctrl[0]
      |=> !park_own && (park_idx == $past(arb_last));
  endproperty
  a_park_last: assert property (p_park_last) else $error("idle bus not parked on last");

  property p_cfg_pass;
    cfg_in.valid && !ctrl[3] |=> (cfg_out == $past(cfg_in));
  endproperty
  a_cfg_pass: assert property (p_cfg_pass) else $error("config cycle altered");
endmodule

// [rpc_link_model.sv]
// Behavioural PCIe link partner that answers each read request with completion data.
`timescale 1ns/100ps
module rpc_link_model
  import rpc_pkg::*;
(
  input  wire logic    pclk,     // Clock.
  input  wire logic    presetn,  // Reset, active low.
  input  rpc_pcie_req_s req,     // Read request from the bridge.
  input  wire logic    slow,     // Answer late.
  output logic         cpl_done  // Completion data arrived.
);
  logic [5:0] cnt_r;

  // Each request is answered once, after a short or a long wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r    <= 6'h00;
      cpl_done <= 1'b0;
    end else begin
      cpl_done <= (cnt_r == 6'h01);
      if (req.valid) begin
        cnt_r <= slow ? 6'h14 : 6'h02;
      end else if (cnt_r != 6'h00) begin
        cnt_r <= cnt_r - 6'h01;
      end
    end
  end
endmodule

// [rpc_top_test.sv]
// Self-checking testbench for the read prefetch control block.
`timescale 1ns/100ps
module rpc_top_test;
  import rpc_pkg::*;
  localparam int DL = 64;
  localparam logic [31:0] RA = 32'h0000_1000;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [3:0]  cmd;
    logic [12:0] len;
    logic        tm;
    logic        tb;
    logic        keep;
  } rpc_case_s;
  localparam logic [12:0] BC [8] = '{13'h200, 13'h80, 13'h100, 13'h200, 13'h400, 13'h800,
                                     13'h1000, 13'h200};
  localparam rpc_case_s CS [12] = '{
    '{16'h0000, RPC_CMD_MRM, RPC_LINE_BYTES, 1'b0, 1'b1, 1'b0},
    '{16'h0010, RPC_CMD_MRM, 13'h200, 1'b0, 1'b1, 1'b1},
    '{16'h0010, RPC_CMD_MRM, 13'h200, 1'b1, 1'b0, 1'b0},
    '{16'h0030, RPC_CMD_MRM, 13'h200, 1'b1, 1'b0, 1'b1},
    '{16'h0020, RPC_CMD_MRM, 13'h200, 1'b0, 1'b1, 1'b0},
    '{16'h0000, RPC_CMD_MRL, RPC_LINE_BYTES, 1'b1, 1'b0, 1'b0},
    '{16'h00A0, RPC_CMD_MRL, 13'h200, 1'b1, 1'b0, 1'b0},
    '{16'h0060, RPC_CMD_MRL, 13'h200, 1'b1, 1'b0, 1'b1},
    '{16'h00E0, RPC_CMD_MRL, 13'h200, 1'b0, 1'b1, 1'b1},
    '{16'h0020, RPC_CMD_MR, RPC_LINE_BYTES, 1'b0, 1'b1, 1'b0},
    '{16'h0220, RPC_CMD_MR, 13'h200, 1'b0, 1'b1, 1'b0},
    '{16'h0320, RPC_CMD_MR, RPC_DWORD_BYTES, 1'b0, 1'b1, 1'b0}};

  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [3:0]    arb_req = 4'h0;
  logic [1:0]    arb_last = 2'h2;
  logic          park_own;
  logic [1:0]    park_idx;
  rpc_rd_req_s   rd_req = '0;
  logic          rd_retry;
  logic          rd_go;
  logic          xfer_end = 1'b0;
  logic          term_master = 1'b0;
  logic          term_bridge = 1'b0;
  logic          data_left = 1'b0;
  rpc_pcie_req_s pcie_req;
  logic          cpl_done;
  rpc_cfg_s      cfg_in = '0;
  rpc_cfg_s      cfg_out;
  logic          dyn_pf_en;
  logic          pred_en;
  logic          malf_chk_en;
  logic          discard_exp;
  logic          slow = 1'b0;
  int            error_cnt = 0;
  int            total_checks = 0;
  int            n;
  logic [31:0]   q;
  logic          e;

  always #4 pclk = ~pclk;

  rpc_top #(.DISCARD_LONG(DL)) i_rpc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .arb_req(arb_req), .arb_last(arb_last),
    .park_own(park_own), .park_idx(park_idx), .rd_req(rd_req), .rd_retry(rd_retry),
    .rd_go(rd_go), .xfer_end(xfer_end), .term_master(term_master),
    .term_bridge(term_bridge), .data_left(data_left), .pcie_req(pcie_req),
    .cpl_done(cpl_done), .cfg_in(cfg_in), .cfg_out(cfg_out), .dyn_pf_en(dyn_pf_en),
    .pred_en(pred_en), .malf_chk_en(malf_chk_en), .discard_exp(discard_exp));

  rpc_link_model i_rpc_link_model (.pclk(pclk), .presetn(presetn), .req(pcie_req),
    .slow(slow), .cpl_done(cpl_done));

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("Checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
      if (k > 20) begin
        error_cnt++;
        summarize();
      end
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk("register", exp, q & m);
  endtask

  // Waits for a link request (0), completion (1) or discard pulse (2); returns the cycles.
  task automatic wait_for(input int sel, input int lim, output int c);
    c = 0;
    do begin
      @(negedge pclk);
      c++;
      if (c > lim) begin
        error_cnt++;
        $display("Error wait %0d expected event seen timeout", sel);
        summarize();
      end
    end while (!((sel == 0 && pcie_req.valid === 1'b1) || (sel == 1 && cpl_done === 1'b1) ||
                 (sel == 2 && discard_exp === 1'b1)));
  endtask

  task automatic req(input logic [3:0] c, input logic rt, input logic go);
    @(posedge pclk);
    rd_req <= '{1'b1, c, RA, 4'hF, 1'b1};
    @(negedge pclk);
    chk("rd_retry", {31'h0, rt}, {31'h0, rd_retry});
    chk("rd_go", {31'h0, go}, {31'h0, rd_go});
    @(posedge pclk);
    rd_req.valid <= 1'b0;
  endtask

  task automatic fetch(input logic [3:0] c, input logic [3:0] rc, input logic [12:0] len,
                       input logic go);
    int c2;
    req(c, 1'b1, 1'b0);
    wait_for(0, 8, c2);
    chk("pcie_len", {19'h0, len}, {19'h0, pcie_req.len});
    chk("pcie_addr", RA, pcie_req.addr);
    wait_for(1, 60, c2);
    req(rc, !go, go);
    if (!go) begin
      req(c, 1'b0, 1'b1);
    end
  endtask

  task automatic fin(input logic tm, input logic tb);
    @(posedge pclk);
    xfer_end <= 1'b1;
    term_master <= tm;
    term_bridge <= tb;
    data_left <= 1'b1;
    @(posedge pclk);
    xfer_end <= 1'b0;
    term_master <= 1'b0;
    term_bridge <= 1'b0;
    data_left <= 1'b0;
  endtask

  task automatic cfg(input logic [31:0] a, input logic t1, input logic [31:0] ea);
    @(posedge pclk);
    cfg_in <= '{1'b1, 1'b0, a};
    @(posedge pclk);
    cfg_in.valid <= 1'b0;
    @(negedge pclk);
    chk("cfg_type1", {31'h0, t1}, {31'h0, cfg_out.type1});
    chk("cfg_addr", ea, cfg_out.addr);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(RPC_ADDR_CTRL, 32'h0000_0020, 32'hFFFF_FFFF);
    rd(RPC_ADDR_AUX, 32'h0, 32'h301);
    chk("dyn_pf_en", 32'h1, {31'h0, dyn_pf_en});
    chk("pred_en", 32'h1, {31'h0, pred_en});
    chk("malf_chk_en", 32'h0, {31'h0, malf_chk_en});
    apb(1'b0, 12'h048, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    apb(1'b1, RPC_ADDR_CTRL, 32'hFFFF_0827);
    rd(RPC_ADDR_CTRL, 32'h0000_0827, 32'hFFFF_FFFF);
    chk("park_own", 32'h1, {31'h0, park_own});
    chk("dyn_pf_en", 32'h0, {31'h0, dyn_pf_en});
    chk("pred_en", 32'h0, {31'h0, pred_en});
    chk("malf_chk_en", 32'h1, {31'h0, malf_chk_en});
    arb_last <= 2'h1;
    apb(1'b1, RPC_ADDR_CTRL, 32'h0000_0028);
    repeat (2) @(negedge pclk);
    chk("park_own", 32'h0, {31'h0, park_own});
    chk("park_idx", 32'h1, {30'h0, park_idx});
    chk("malf_chk_en", 32'h0, {31'h0, malf_chk_en});
    // Requester side encodes bus, device and function in Type 1 layout.
    cfg(32'hF001_0A04, 1'b1, 32'hF001_0A05);
    cfg(32'hF001_0A07, 1'b1, 32'hF001_0A05);
    cfg(32'h7001_0A04, 1'b0, 32'h7001_0A04);
    apb(1'b1, RPC_ADDR_CTRL, 32'h0000_0020);
    cfg(32'hF001_0A04, 1'b0, 32'hF001_0A04);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, RPC_ADDR_CTRL, 32'h0000_0020 | (i << 12));
      fetch(RPC_CMD_MRM, RPC_CMD_MRM, BC[i], 1'b1);
      fin(1'b0, 1'b1);
    end
    for (int i = 0; i < 12; i++) begin
      apb(1'b1, RPC_ADDR_CTRL, {16'h0, CS[i].ctrl});
      slow <= i[0];
      fetch(CS[i].cmd, CS[i].cmd, CS[i].len, 1'b1);
      fin(CS[i].tm, CS[i].tb);
      if (CS[i].keep) begin
        wait_for(2, 4 * DL, n);
        chk("discard_cycles", DL, (n >= DL - 3 && n <= DL + 3) ? DL : n);
      end
      rd(RPC_ADDR_AUX, 32'h0, 32'h300);
    end
    apb(1'b1, RPC_ADDR_CTRL, 32'h0000_0020);
    fetch(RPC_CMD_MRM, RPC_CMD_MRL, 13'h200, 1'b0);
    fin(1'b0, 1'b0);
    apb(1'b1, RPC_ADDR_CTRL, 32'h0000_0420);
    fetch(RPC_CMD_MRM, RPC_CMD_MRL, 13'h200, 1'b1);
    fin(1'b0, 1'b0);
    apb(1'b1, RPC_ADDR_AUX, 32'h1);
    rd(RPC_ADDR_AUX, 32'h1, 32'h1);
    apb(1'b1, RPC_ADDR_CTRL, 32'h0000_0010);
    fetch(RPC_CMD_MRM, RPC_CMD_MRM, 13'h200, 1'b1);
    fin(1'b0, 1'b1);
    wait_for(2, 1200, n);
    chk("discard_cycles", 1024, (n >= 1021 && n <= 1027) ? 1024 : n);
    summarize();
  end
endmodule
